/* rtl/prioritized_vector_interrupt.sv */
// Purpose: Prioritized vectored interrupt controller for an 8-bit core.
// Assumes: Sources give one-cycle event pulses synchronous to core_clk_i.
// Notes:   Software port: address, write data, strobes, read data next cycle.
`timescale 1ns/1ps
// Function
// [R1] Fifteen sources: nine external, six internal.
// [R2] Fixed vector per source, rank 0 highest.
// [R3] Maskable needs global and own enable; watchdog own.
// [R4] Each request recorded in flag, three registers.
// [R5] Two mask registers enable sources individually.
// [R6] Enable instruction sets, disable instruction clears global.
// [R7] Enabled interrupt redirects fetch to its vector.
// [R8] Service routine clears flag before return.
// [R9] Third status flags set regardless of enables.
// [R10] Return instruction ends service, sets global enable.
// [R11] Lowest rank wins among simultaneous requests.
module prioritized_vector_interrupt (
   input  wire logic                            core_clk_i,
   input  wire logic                            rst_i,
   input  wire logic [irq_pkg::NUM_SRC-1:0]     event_i,
   input  wire logic                            global_irq_on_instr_i,
   input  wire logic                            global_irq_off_instr_i,
   input  wire logic                            return_from_isr_instr_i,
   input  wire logic                            fetch_ack_i,
   input  wire logic [irq_pkg::ADDR_W-1:0]      reg_addr_i,
   input  wire logic [irq_pkg::DATA_W-1:0]      reg_wdata_i,
   input  wire logic                            reg_wr_i,
   input  wire logic                            reg_rd_i,
   output logic      [irq_pkg::DATA_W-1:0]      reg_rdata_o,
   output logic                                 vector_fetch_o,
   output logic      [irq_pkg::VEC_W-1:0]       vector_addr_o,
   output logic                                 irq_o,
   output logic                                 global_en_o
);

   logic [irq_pkg::NUM_SRC-1:0]  flag_q;
   logic [irq_pkg::NUM_SRC-1:0]  clr_mask;
   logic [irq_pkg::NUM_SRC-1:0]  mask_vec;
   logic [irq_pkg::NUM_SRC-1:0]  enabled_req;
   logic [irq_pkg::DATA_W-1:0]   mask_a_q;
   logic [irq_pkg::DATA_W-1:0]   mask_b_q;
   logic                         gie_q;
   logic                         wdog_en_q;
   irq_pkg::irq_state_t          state_q;
   logic                         pick_any;
   logic [irq_pkg::RANK_W-1:0]   pick_rank;
   logic [irq_pkg::VEC_W-1:0]    pick_vec;

   // True when the write strobe targets the given offset.
   function automatic logic wr_hit(input logic [irq_pkg::ADDR_W-1:0] a,
                                   input logic [irq_pkg::ADDR_W-1:0] ofs,
                                   input logic wr);
      return wr && (a == ofs);
   endfunction

   // Clear strobes: status a holds ranks 0..7, b ranks 8..15.
   // Status c mirrors the peripheral flags of ranks 8..14 and reads zero at the
   // input-change flag position, sharing storage with b.
   always_comb begin
      clr_mask = '0;
      if (wr_hit(reg_addr_i, irq_pkg::OFS_CLR_A, reg_wr_i)) begin
         clr_mask[7:0] = reg_wdata_i;
      end else if (wr_hit(reg_addr_i, irq_pkg::OFS_CLR_B, reg_wr_i)) begin
         clr_mask[15:8] = reg_wdata_i;
      end else if (wr_hit(reg_addr_i, irq_pkg::OFS_CLR_C, reg_wr_i)) begin
         clr_mask[15:8] = reg_wdata_i;
      end
   end

   // Sticky flags; a new event wins over a clear in the same cycle.
   // The reset source is not latched: reset itself restarts at vector 0.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         flag_q <= '0;
      end else begin
         flag_q <= ((flag_q & ~clr_mask) | event_i)   // [R4] [R9]
                   & ~irq_pkg::NUM_SRC'(1);            // [R1]
      end
   end

   // Mask registers; bit n of a maps to rank n+2, b to ranks 10..15.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mask_a_q <= irq_pkg::MASK_RST;
         mask_b_q <= irq_pkg::MASK_RST;
      end else begin
         if (wr_hit(reg_addr_i, irq_pkg::OFS_MASK_A, reg_wr_i)) begin
            mask_a_q <= reg_wdata_i;                   // [R5]
         end
         if (wr_hit(reg_addr_i, irq_pkg::OFS_MASK_B, reg_wr_i)) begin
            mask_b_q <= reg_wdata_i;                   // [R5]
         end
      end
   end

   // Watchdog enable is a control bit of its own.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wdog_en_q <= irq_pkg::WDOG_EN_RST;
      end else if (wr_hit(reg_addr_i, irq_pkg::OFS_CTRL, reg_wr_i)) begin
         wdog_en_q <= reg_wdata_i[irq_pkg::CTRL_WDOG_BIT];
      end
   end

   // Global enable: set by enable or return, cleared by disable and by
   // taking an interrupt so the handler is not re-entered.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         gie_q <= 1'b0;
      end else if (global_irq_on_instr_i || return_from_isr_instr_i) begin
         gie_q <= 1'b1;                                // [R6] [R10]
      end else if (global_irq_off_instr_i) begin
         gie_q <= 1'b0;                                // [R6]
      end else if (state_q == irq_pkg::ST_VECTOR && fetch_ack_i) begin
         gie_q <= 1'b0;                                // [R8]
      end else if (wr_hit(reg_addr_i, irq_pkg::OFS_CTRL, reg_wr_i)) begin
         gie_q <= reg_wdata_i[irq_pkg::CTRL_GIE_BIT];
      end
   end

   // Enable vector per rank.
   always_comb begin
      mask_vec = '0;
      mask_vec[irq_pkg::SRC_WDOG] = wdog_en_q;               // [R3]
      mask_vec[9:2]   = mask_a_q & {irq_pkg::DATA_W{gie_q}};  // [R3]
      mask_vec[15:10] = mask_b_q[5:0] & {6{gie_q}};           // [R3]
      enabled_req = flag_q & mask_vec;
   end

   irq_prio_pick u_pick (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .req_i      (enabled_req),
      .any_o      (pick_any),
      .rank_o     (pick_rank),
      .vector_o   (pick_vec)
   );

   // Redirect sequencer: raise fetch with vector until the core accepts.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_q        <= irq_pkg::ST_RUN;
         vector_fetch_o <= 1'b0;
         vector_addr_o  <= '0;
      end else begin
         case (state_q)
            irq_pkg::ST_RUN: begin
               if (pick_any && (|enabled_req)) begin
                  state_q        <= irq_pkg::ST_VECTOR;
                  vector_fetch_o <= 1'b1;              // [R7]
                  vector_addr_o  <= pick_vec;          // [R2] [R11]
               end
            end
            irq_pkg::ST_VECTOR: begin
               if (fetch_ack_i) begin
                  state_q        <= irq_pkg::ST_SERVICE;
                  vector_fetch_o <= 1'b0;
               end
            end
            irq_pkg::ST_SERVICE: begin
               if (return_from_isr_instr_i) begin
                  state_q <= irq_pkg::ST_RUN;          // [R10]
               end
            end
            default: begin
               state_q        <= irq_pkg::ST_RUN;
               vector_fetch_o <= 1'b0;
            end
         endcase
      end
   end

   // Level interrupt and global enable view, both registered.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_o       <= 1'b0;
         global_en_o <= 1'b0;
      end else begin
         irq_o       <= |enabled_req;
         global_en_o <= gie_q;
      end
   end

   // Read data appear the cycle after the read strobe; unmapped read zero.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         reg_rdata_o <= irq_pkg::ZERO_BYTE;
      end else if (reg_rd_i) begin
         if (reg_addr_i == irq_pkg::OFS_STAT_A) begin
            reg_rdata_o <= flag_q[7:0];
         end else if (reg_addr_i == irq_pkg::OFS_STAT_B) begin
            reg_rdata_o <= flag_q[15:8];
         end else if (reg_addr_i == irq_pkg::OFS_STAT_C) begin
            reg_rdata_o <= {1'b0, flag_q[14:8]};       // [R9]
         end else if (reg_addr_i == irq_pkg::OFS_MASK_A) begin
            reg_rdata_o <= mask_a_q;
         end else if (reg_addr_i == irq_pkg::OFS_MASK_B) begin
            reg_rdata_o <= mask_b_q;
         end else if (reg_addr_i == irq_pkg::OFS_CTRL) begin
            reg_rdata_o <= {6'h00, wdog_en_q, gie_q};
         end else if (reg_addr_i == irq_pkg::OFS_VECTOR) begin
            reg_rdata_o <= {4'h0, pick_rank};
         end else begin
            reg_rdata_o <= irq_pkg::ZERO_BYTE;
         end
      end
   end

endmodule

/* rtl/irq_pkg.sv */
// Purpose: Shared constants for the prioritized vectored interrupt block.
// Assumes: One core clock, synchronous active-high reset.
// Notes:   Register offsets and bit layouts of the software port live here.
package irq_pkg;

   localparam int unsigned NUM_SRC     = 16;
   localparam int unsigned NUM_MASK    = 14;
   localparam int unsigned ADDR_W      = 4;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned VEC_W       = 8;
   localparam int unsigned RANK_W      = 4;

   // Source ranks (index equals priority rank).
   localparam int unsigned SRC_RESET   = 0;
   localparam int unsigned SRC_WDOG    = 1;
   localparam int unsigned SRC_FIRST_M = 2;

   // Register offsets on the software port.
   localparam logic [ADDR_W-1:0] OFS_STAT_A  = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STAT_B  = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_STAT_C  = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_MASK_A  = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_MASK_B  = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_CLR_A   = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_CLR_B   = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_CLR_C   = 4'h7;
   localparam logic [ADDR_W-1:0] OFS_CTRL    = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_VECTOR  = 4'h9;

   // Control register layout.
   localparam int unsigned CTRL_GIE_BIT  = 0;
   localparam int unsigned CTRL_WDOG_BIT = 1;

   // Reset values.
   localparam logic [DATA_W-1:0] MASK_RST   = 8'h00;
   localparam logic              WDOG_EN_RST = 1'b0;
   localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;

   // Index of the input-change flag inside status register c.
   localparam int unsigned ICF_BIT = 7;

   // Vector table, indexed by rank.
   localparam logic [VEC_W-1:0] VECTOR_TABLE [NUM_SRC] = '{
      8'h00, 8'h03, 8'h06, 8'h09, 8'h0F, 8'h12, 8'h15, 8'h18,
      8'h1B, 8'h21, 8'h24, 8'h27, 8'h2A, 8'h30, 8'h33, 8'h36};

   typedef enum logic [2:0] {
      ST_RUN     = 3'b001,
      ST_VECTOR  = 3'b010,
      ST_SERVICE = 3'b100
   } irq_state_t;

endpackage

/* rtl/irq_prio_pick.sv */
// Purpose: Picks the lowest-ranked asserted request and its vector.
// Assumes: Request bit index equals priority rank.
// Notes:   Outputs are registered, giving one cycle of latency.
`timescale 1ns/1ps
module irq_prio_pick (
   input  wire logic                                core_clk_i,
   input  wire logic                                rst_i,
   input  wire logic [irq_pkg::NUM_SRC-1:0]         req_i,
   output logic                                     any_o,
   output logic      [irq_pkg::RANK_W-1:0]          rank_o,
   output logic      [irq_pkg::VEC_W-1:0]           vector_o
);

   // Returns the lowest index with a set bit.
   function automatic logic [irq_pkg::RANK_W-1:0] first_set(
      input logic [irq_pkg::NUM_SRC-1:0] v);
      logic [irq_pkg::RANK_W-1:0] r;
      r = '0;
      for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = irq_pkg::RANK_W'(i);
         end
      end
      return r;
   endfunction

   // Registers the winner so the vector comes straight from a flip-flop.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         any_o    <= 1'b0;
         rank_o   <= '0;
         vector_o <= '0;
      end else begin
         any_o    <= |req_i;
         rank_o   <= first_set(req_i);                       // [R11]
         vector_o <= irq_pkg::VECTOR_TABLE[first_set(req_i)]; // [R2]
      end
   end

endmodule

/* sim/irq_core_model.sv */
// Purpose: Behavioural core that accepts vector fetches from the block.
// Assumes: The bench sets the acknowledge delay before each transfer.
// Notes:   Acknowledge is a one-cycle pulse while the fetch request stands.
`timescale 1ns/1ps
module irq_core_model (
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       vector_fetch_i,
   input  wire logic [3:0] ack_delay_i,
   output logic            fetch_ack_o
);
   logic [3:0] wait_q;
   // Waits the set delay, then takes the vector once; slow answers stress the hold.
   always_ff @(posedge core_clk_i) begin
      if (rst_i || !vector_fetch_i || fetch_ack_o) begin
         wait_q      <= 4'h0;
         fetch_ack_o <= 1'b0;
      end else if (wait_q == ack_delay_i) begin
         fetch_ack_o <= 1'b1;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule

/* sim/irq_checker_sva.sv */
// Purpose: Port-level checks of the interrupt block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the block below the module.
`timescale 1ns/1ps
module irq_checker_sva (
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   input wire logic [15:0] event_i,
   input wire logic        global_irq_on_instr_i,
   input wire logic        global_irq_off_instr_i,
   input wire logic        return_from_isr_instr_i,
   input wire logic        fetch_ack_i,
   input wire logic [3:0]  reg_addr_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [7:0]  reg_rdata_o,
   input wire logic        vector_fetch_o,
   input wire logic [7:0]  vector_addr_o,
   input wire logic        irq_o,
   input wire logic        global_en_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // A write or an event, one quiet cycle, then a read of the affected register.
   sequence s_evt_a; event_i[2] ##1 !reg_wr_i ##1 (reg_rd_i && reg_addr_i == 4'h0); endsequence
   sequence s_evt_c; event_i[10] ##1 !reg_wr_i ##1 (reg_rd_i && reg_addr_i == 4'h2); endsequence
   sequence s_mask; (reg_wr_i && reg_addr_i == 4'h3) ##1 !reg_wr_i ##1 (reg_rd_i && reg_addr_i == 4'h3);
   endsequence
   // The global enable output is a registered copy, so it follows one edge late.
   property p_on; global_irq_on_instr_i |=> ##1 global_en_o; endproperty
   a_on: assert property (p_on) else $error("enable instruction ignored");
   property p_off; global_irq_off_instr_i && !global_irq_on_instr_i && !return_from_isr_instr_i
      |=> ##1 !global_en_o; endproperty
   a_off: assert property (p_off) else $error("disable instruction ignored");
   property p_ret; return_from_isr_instr_i |=> ##1 global_en_o; endproperty
   a_ret: assert property (p_ret) else $error("return did not enable");
   property p_hold; vector_fetch_o && !fetch_ack_i |=> vector_fetch_o && $stable(vector_addr_o);
   endproperty
   a_hold: assert property (p_hold) else $error("vector request not held");
   property p_ack; vector_fetch_o && fetch_ack_i && !global_irq_on_instr_i
      && !return_from_isr_instr_i |=> !vector_fetch_o ##1 !global_en_o; endproperty
   a_ack: assert property (p_ack) else $error("vector not released on accept");
   property p_cause; $rose(vector_fetch_o) |-> $past(irq_o); endproperty
   a_cause: assert property (p_cause) else $error("vector without pending request");
   property p_table; $rose(vector_fetch_o) |-> vector_addr_o inside {8'h03, 8'h06, 8'h09, 8'h0F,
      8'h12, 8'h15, 8'h18, 8'h1B, 8'h21, 8'h24, 8'h27, 8'h2A, 8'h30, 8'h33, 8'h36}; endproperty
   a_table: assert property (p_table) else $error("vector address not in table");
   property p_unmapped; reg_rd_i && reg_addr_i > 4'h9 |=> reg_rdata_o == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_flag_a; s_evt_a |=> reg_rdata_o[2]; endproperty
   a_flag_a: assert property (p_flag_a) else $error("flag not recorded");
   property p_flag_c; s_evt_c |=> reg_rdata_o[2] && !reg_rdata_o[7]; endproperty
   a_flag_c: assert property (p_flag_c) else $error("third status flag wrong");
   property p_mask; s_mask |=> reg_rdata_o == $past(reg_wdata_i, 3); endproperty
   a_mask: assert property (p_mask) else $error("mask readback wrong");
endmodule
bind prioritized_vector_interrupt irq_checker_sva i_irq_checker_sva (.core_clk_i, .rst_i,
   .event_i, .global_irq_on_instr_i, .global_irq_off_instr_i, .return_from_isr_instr_i,
   .fetch_ack_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
   .vector_fetch_o, .vector_addr_o, .irq_o, .global_en_o);

/* sim/prioritized_vector_interrupt_test.sv */
// Purpose: Self-checking bench for the prioritized vectored interrupt block.
// Assumes: The core model acknowledges fetches after a random delay.
// Notes:   The bench plays the service routine: clear flags, then return.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
$display("ERROR %0t got %h exp %h", $time, g, e); end end
module prioritized_vector_interrupt_test;
   logic        core_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [15:0] ev = 16'h0000, e;
   logic [2:0]  ins = 3'h0;
   logic [3:0]  addr = 4'h0, dly = 4'h0;
   logic [7:0]  wdata = 8'h00, rdata, got, vaddr;
   logic        wr = 1'b0, rd = 1'b0, ack, fetch, irq, gie;
   integer      seed = 32'hB34C, n_errors = 0, comparisons = 0, r, k, w;
   integer      exp_q[$];
   logic [7:0]  vt [16] = '{8'h00, 8'h03, 8'h06, 8'h09, 8'h0F, 8'h12, 8'h15, 8'h18,
                            8'h1B, 8'h21, 8'h24, 8'h27, 8'h2A, 8'h30, 8'h33, 8'h36};
   prioritized_vector_interrupt i_prioritized_vector_interrupt (.core_clk_i, .rst_i,
      .event_i(ev), .global_irq_on_instr_i(ins[0]), .global_irq_off_instr_i(ins[1]),
      .return_from_isr_instr_i(ins[2]), .fetch_ack_i(ack), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .vector_fetch_o(fetch), .vector_addr_o(vaddr), .irq_o(irq), .global_en_o(gie));
   irq_core_model i_irq_core_model (.core_clk_i, .rst_i, .vector_fetch_i(fetch),
      .ack_delay_i(dly), .fetch_ack_o(ack));
   always #2 core_clk_i = ~core_clk_i;
   // Bus and stimulus tasks; each drives after an edge and releases after the next.
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk_i);
      wr    <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a);
      @(posedge core_clk_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk_i);
      rd   <= 1'b0;
      #1;
      got = rdata;
   endtask
   task automatic pulse(input logic [15:0] v, input logic [2:0] i);
      @(posedge core_clk_i);
      ev  <= v;
      ins <= i;
      @(posedge core_clk_i);
      ev  <= 16'h0000;
      ins <= 3'h0;
   endtask
   // Pulses one instruction; the registered global enable output shows it an edge later.
   task automatic instr(input logic [2:0] i);
      pulse(16'h0000, i);
      @(posedge core_clk_i);
      #1;
   endtask
   // Waits for the vector, compares it, then waits for the core to take it.
   task automatic take(input integer n);
      for (k = 0; k < 40 && fetch !== 1'b1; k++) @(posedge core_clk_i) #1;
      `CHK(fetch, 1'b1)
      `CHK(irq, 1'b1)
      `CHK(vaddr, vt[n])
      for (k = 0; k < 40 && fetch === 1'b1; k++) @(posedge core_clk_i) #1;
      `CHK(fetch, 1'b0)
      @(posedge core_clk_i);
      #1;
      `CHK(gie, 1'b0)
   endtask
   task automatic service();
      wreg(irq_pkg::OFS_CLR_A, 8'hFF);
      wreg(irq_pkg::OFS_CLR_B, 8'hFF);
      instr(3'b100);
      `CHK(gie, 1'b1)
   endtask
   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Main sequence: reset values, priority sweep, watchdog path, masking.
   initial begin
      repeat (8) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rreg(4'hF);
      `CHK(got, 8'h00)
      rreg(irq_pkg::OFS_MASK_B);
      `CHK(got, irq_pkg::MASK_RST)
      `CHK({fetch, irq, gie}, 3'b000)
      wreg(irq_pkg::OFS_MASK_B, 8'h3F);
      wreg(irq_pkg::OFS_MASK_A, 8'hFF);
      rreg(irq_pkg::OFS_MASK_A);
      `CHK(got, 8'hFF)
      instr(3'b001);
      `CHK(gie, 1'b1)
      for (r = 2; r < 16; r++) begin
         dly <= 4'($random(seed));
         e = (16'h0001 << r) | (16'($random(seed)) << (r + 1));
         for (k = 15; k >= 2; k--)
            if (e[k]) w = k;
         exp_q.push_back(w);
         pulse(e, 3'b000);
         take(exp_q.pop_front());
         rreg(irq_pkg::OFS_STAT_A);
         `CHK(got, e[7:0])
         rreg(irq_pkg::OFS_STAT_B);
         `CHK(got, e[15:8])
         rreg(irq_pkg::OFS_STAT_C);
         `CHK(got, {1'b0, e[14:8]})
         service();
      end
      instr(3'b010);
      `CHK(gie, 1'b0)
      wreg(irq_pkg::OFS_CTRL, 8'h02);
      rreg(irq_pkg::OFS_CTRL);
      `CHK(got, 8'h02)
      pulse(16'h0006, 3'b000);
      take(1);
      service();
      wreg(irq_pkg::OFS_MASK_A, 8'hFE);
      wreg(irq_pkg::OFS_MASK_B, 8'h00);
      pulse(16'h0004, 3'b000);
      rreg(irq_pkg::OFS_STAT_A);
      `CHK(got, 8'h04)
      pulse(16'h0400, 3'b000);
      rreg(irq_pkg::OFS_STAT_C);
      `CHK(got, 8'h04)
      repeat (6) @(posedge core_clk_i);
      #1;
      `CHK(fetch, 1'b0)
      `CHK(irq, 1'b0)
      wreg(irq_pkg::OFS_MASK_A, 8'hFF);
      take(2);
      service();
      tally_and_finish();
   end
   // Cuts a hang short well beyond the expected run time.
   initial begin
      #40000;
      n_errors++;
      tally_and_finish();
   end
endmodule
